// ---- hw/csbam_top.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE1 - with address setup, no write enable on zero-wait writes
// RULE2 - first clock: address, attributes, read, size, start; select held off with setup
// RULE3 - second clock: start off, mode shows supervisor, select on
// RULE4 - 8-bit port bytes come on top lane, latched when ack sampled
// RULE5 - ack negated means wait states, resample every edge
// RULE6 - bus monitor expiry ends cycle with bus error
// RULE7 - after first setup-burst beat, select drops after next edge
// RULE8 - read hold keeps address and attributes one more clock per read beat
// RULE9 - next byte bumps low address, select off one clock with setup
// RULE10 - final beat ack ends transfer and drops select
// RULE11 - alternate cycles only when bus granted and master drives start
// RULE12 - latch address, direction, size on edge start is seen
// RULE13 - upper four address bits read zero when pins not address
// RULE14 - alternate cycles ignore type, mode and privilege mask bits
// RULE15 - sequence starts next edge; select only if enabled for direction
// RULE16 - auto ack region drives and asserts ack at programmed time
// RULE17 - no address drive during alternate master accesses
// RULE18 - unmatched address uses default memory auto ack after wait count
// RULE19 - burst enabled and size over port size runs a burst
// RULE20 - alternate master avoids oversize requests when burst disabled
// RULE21 - after final beat drop select and ack, then release ack
// RULE22 - no setup/hold gaps in single beats; one gap clock per bit in bursts
module csbam_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [27:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [1:0] req_type,
    input wire logic req_super,
    input wire logic req_code,
    input wire logic [31:0] req_wdata,
    output logic req_busy,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [31:0] rsp_rdata,
    input wire logic [11:0] region_base,
    input wire logic [11:0] region_dont_care,
    input wire logic region_read_enable,
    input wire logic region_write_enable,
    input wire logic [1:0] region_port_size,
    input wire logic region_burst_enable,
    input wire logic address_setup_enable,
    input wire logic region_read_hold,
    input wire logic region_write_hold,
    input wire logic region_auto_ack_enable,
    input wire logic [3:0] region_wait_count,
    input wire logic super_code_mask,
    input wire logic super_data_mask,
    input wire logic user_code_mask,
    input wire logic user_data_mask,
    input wire logic [1:0] dflt_port_size,
    input wire logic dflt_burst_enable,
    input wire logic dflt_auto_ack_enable,
    input wire logic [3:0] dflt_wait_count,
    input wire logic upper_pins_are_addr,
    input wire logic bmon_enable,
    input wire logic [7:0] bmon_limit,
    input wire logic bus_granted,
    input wire logic dram_hit,
    input wire logic [27:0] addr_in,
    input wire logic alt_write,
    input wire logic [1:0] alt_size,
    input wire logic transfer_start_n_in,
    input wire logic transfer_ack_n_in,
    input wire logic [31:0] data_in,
    output logic [27:0] addr_out,
    output logic addr_oe,
    output logic transfer_start_n,
    output logic transfer_start_oe,
    output logic [1:0] transfer_type,
    output logic access_type_mode,
    output logic rd_wr_n,
    output logic [1:0] size_code,
    output logic [3:0] byte_we_n,
    output logic chip_sel_n,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    output logic [31:0] data_out,
    output logic data_oe
);
    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [2:0] lg_bytes(input logic [1:0] c);
        case (c)
            csbam_pkg::SZ_BYTE: lg_bytes = 3'h0;
            csbam_pkg::SZ_WORD: lg_bytes = 3'h1;
            csbam_pkg::SZ_LINE: lg_bytes = 3'h4;
            default: lg_bytes = 3'h2;
        endcase
    endfunction
    function automatic logic [4:0] beats_of(input logic [1:0] sz, input logic [1:0] ps, input logic be);
        logic [2:0] ls;
        logic [2:0] lp;
        ls = lg_bytes(sz);
        lp = lg_bytes(ps);
        if (be && ls > lp) begin // [RULE19]
            beats_of = 5'(csbam_pkg::BEAT_ONE << (ls - lp));
        end else begin
            beats_of = csbam_pkg::BEAT_ONE;
        end
    endfunction
    function automatic logic region_hit(input logic [27:0] a);
        region_hit = ((a[27:csbam_pkg::BASE_LSB] ^ region_base) & ~region_dont_care) == 12'h000;
    endfunction
    function automatic logic [3:0] lane_we(input logic [1:0] ps);
        case (ps)
            csbam_pkg::SZ_BYTE: lane_we = csbam_pkg::WE_P8;
            csbam_pkg::SZ_WORD: lane_we = csbam_pkg::WE_P16;
            default: lane_we = csbam_pkg::WE_P32;
        endcase
    endfunction
    function automatic logic [31:0] lane_in(input logic [31:0] acc, input logic [31:0] d, input logic [1:0] ps);
        case (ps)
            csbam_pkg::SZ_BYTE: lane_in = {acc[23:0], d[31:24]};
            csbam_pkg::SZ_WORD: lane_in = {acc[15:0], d[31:16]};
            default: lane_in = d;
        endcase
    endfunction

    // ****************************************
    // own-master sequencer
    // ****************************************
    csbam_pkg::csbam_own_e own_q, own_d;
    logic [27:0] oaddr_q, oaddr_d;
    logic [31:0] odata_q, odata_d, rdata_q, rdata_d;
    logic [4:0] obeats_q, obeats_d;
    logic [7:0] dcnt_q, dcnt_d;
    logic [1:0] ops_q, ops_d, osz_q, osz_d, ott_q, ott_d;
    logic owr_q, owr_d, ocs_q, ocs_d, oaset_q, oaset_d, ohold_q, ohold_d;
    logic osup_q, osup_d, ocode_q, ocode_d, olast_q, olast_d;
    logic ok_d, err_d;
    logic take, own_hit, own_masked, oack;
    csbam_pkg::csbam_alt_e alt_q, alt_d;

    assign own_hit = region_hit(req_addr);
    // privilege masks apply to own cycles only
    assign own_masked = req_super ? (req_code ? super_code_mask : super_data_mask)
                                  : (req_code ? user_code_mask : user_data_mask);
    assign take = req_valid && !bus_granted && alt_q == csbam_pkg::A_IDLE;
    assign oack = !transfer_ack_n_in;

    always_comb begin
        own_d = own_q;
        oaddr_d = oaddr_q;
        odata_d = odata_q;
        rdata_d = rdata_q;
        obeats_d = obeats_q;
        dcnt_d = dcnt_q;
        ops_d = ops_q;
        osz_d = osz_q;
        ott_d = ott_q;
        owr_d = owr_q;
        ocs_d = ocs_q;
        oaset_d = oaset_q;
        ohold_d = ohold_q;
        osup_d = osup_q;
        ocode_d = ocode_q;
        olast_d = olast_q;
        ok_d = 1'b0;
        err_d = 1'b0;
        case (own_q)
            csbam_pkg::O_IDLE: begin
                if (take) begin
                    own_d = csbam_pkg::O_START;
                    oaddr_d = req_addr;
                    odata_d = req_wdata;
                    osz_d = req_size;
                    ott_d = req_type;
                    owr_d = req_write;
                    osup_d = req_super;
                    ocode_d = req_code;
                    olast_d = 1'b0;
                    ocs_d = own_hit && !own_masked && (req_write ? region_write_enable : region_read_enable);
                    ops_d = own_hit ? region_port_size : dflt_port_size;
                    obeats_d = own_hit ? beats_of(req_size, region_port_size, region_burst_enable)
                                       : beats_of(req_size, dflt_port_size, dflt_burst_enable);
                    oaset_d = own_hit && address_setup_enable;
                    ohold_d = own_hit && (req_write ? region_write_hold : region_read_hold);
                end
            end
            csbam_pkg::O_START: begin
                own_d = csbam_pkg::O_DATA; // [RULE3]
                dcnt_d = 8'h00;
            end
            csbam_pkg::O_DATA: begin
                if (oack) begin
                    dcnt_d = 8'h00;
                    rdata_d = lane_in(rdata_q, data_in, ops_q); // [RULE4]
                    odata_d = 32'(odata_q << (8 << lg_bytes(ops_q)));
                    if (obeats_q == csbam_pkg::BEAT_ONE) begin
                        ok_d = 1'b1;
                        olast_d = 1'b1;
                        own_d = ohold_q ? csbam_pkg::O_HOLD : csbam_pkg::O_IDLE; // [RULE10]
                    end else begin
                        obeats_d = obeats_q - 5'h01;
                        if (ohold_q) begin
                            own_d = csbam_pkg::O_HOLD; // [RULE8]
                        end else begin
                            oaddr_d = oaddr_q + 28'(1 << lg_bytes(ops_q));
                            own_d = oaset_q ? csbam_pkg::O_SETUP : csbam_pkg::O_DATA; // [RULE7]
                        end
                    end
                end else if (bmon_enable && dcnt_q >= bmon_limit) begin
                    err_d = 1'b1; // [RULE6]
                    own_d = csbam_pkg::O_IDLE;
                end else begin
                    dcnt_d = dcnt_q + 8'h01; // [RULE5]
                end
            end
            csbam_pkg::O_HOLD: begin
                if (olast_q) begin
                    own_d = csbam_pkg::O_IDLE;
                end else begin
                    oaddr_d = oaddr_q + 28'(1 << lg_bytes(ops_q)); // [RULE9]
                    own_d = oaset_q ? csbam_pkg::O_SETUP : csbam_pkg::O_DATA;
                end
            end
            csbam_pkg::O_SETUP: begin
                own_d = csbam_pkg::O_DATA;
            end
            default: begin
                own_d = csbam_pkg::O_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            own_q <= csbam_pkg::O_IDLE;
            oaddr_q <= 28'h0000000;
            odata_q <= 32'h00000000;
            rdata_q <= 32'h00000000;
            obeats_q <= csbam_pkg::BEAT_ONE;
            dcnt_q <= 8'h00;
            ops_q <= 2'h0;
            osz_q <= 2'h0;
            ott_q <= 2'h0;
            {owr_q, ocs_q, oaset_q, ohold_q, osup_q, ocode_q, olast_q} <= 7'h00;
        end else begin
            own_q <= own_d;
            oaddr_q <= oaddr_d;
            odata_q <= odata_d;
            rdata_q <= rdata_d;
            obeats_q <= obeats_d;
            dcnt_q <= dcnt_d;
            ops_q <= ops_d;
            osz_q <= osz_d;
            ott_q <= ott_d;
            {owr_q, ocs_q, oaset_q, ohold_q, osup_q, ocode_q, olast_q} <=
                {owr_d, ocs_d, oaset_d, ohold_d, osup_d, ocode_d, olast_d};
        end
    end

    // ****************************************
    // alternate-master sequencer
    // ****************************************
    logic [27:0] aaddr_q, aaddr_d;
    logic [1:0] asz_q, asz_d, aps_q, aps_d, agap_q, agap_d, gcnt_q, gcnt_d;
    logic [4:0] abeats_q, abeats_d;
    logic [3:0] aws_q, aws_d, acnt_q, acnt_d;
    logic awr_q, awr_d, acs_q, acs_d, aack_q, aack_d;
    logic alt_hit, alt_dir, beat_done;

    // type, mode and privilege masks are not consulted here [RULE14]
    assign alt_hit = region_hit(aaddr_q);
    assign alt_dir = awr_q ? region_write_enable : region_read_enable;
    assign beat_done = alt_q == csbam_pkg::A_ACT && (aack_q ? acnt_q >= aws_q : oack);

    always_comb begin
        alt_d = alt_q;
        aaddr_d = aaddr_q;
        asz_d = asz_q;
        awr_d = awr_q;
        aps_d = aps_q;
        agap_d = agap_q;
        gcnt_d = gcnt_q;
        abeats_d = abeats_q;
        aws_d = aws_q;
        acnt_d = acnt_q;
        acs_d = acs_q;
        aack_d = aack_q;
        case (alt_q)
            csbam_pkg::A_IDLE: begin
                if (bus_granted && !transfer_start_n_in && own_q == csbam_pkg::O_IDLE) begin // [RULE11]
                    alt_d = csbam_pkg::A_DEC;
                    aaddr_d = addr_in; // [RULE12]
                    if (!upper_pins_are_addr) begin
                        aaddr_d[27:csbam_pkg::UPPER_LSB] = 4'h0; // [RULE13]
                    end
                    asz_d = alt_size;
                    awr_d = alt_write;
                end
            end
            csbam_pkg::A_DEC: begin
                acnt_d = 4'h0;
                gcnt_d = 2'h0;
                acs_d = alt_hit && alt_dir; // [RULE15]
                if (alt_hit) begin
                    aps_d = region_port_size;
                    abeats_d = beats_of(asz_q, region_port_size, region_burst_enable);
                    aack_d = region_auto_ack_enable; // [RULE16]
                    aws_d = region_wait_count;
                    agap_d = 2'(address_setup_enable) + 2'(awr_q ? region_write_hold : region_read_hold);
                    alt_d = alt_dir ? csbam_pkg::A_ACT : csbam_pkg::A_IDLE;
                end else begin
                    aps_d = dflt_port_size;
                    abeats_d = beats_of(asz_q, dflt_port_size, dflt_burst_enable);
                    aack_d = dflt_auto_ack_enable; // [RULE18]
                    aws_d = dflt_wait_count;
                    agap_d = 2'h0;
                    alt_d = (!dram_hit && dflt_auto_ack_enable) ? csbam_pkg::A_ACT : csbam_pkg::A_IDLE;
                end
            end
            csbam_pkg::A_ACT: begin
                if (beat_done) begin
                    acnt_d = 4'h0;
                    if (abeats_q == csbam_pkg::BEAT_ONE) begin
                        alt_d = csbam_pkg::A_END; // [RULE21]
                    end else begin
                        abeats_d = abeats_q - 5'h01;
                        if (agap_q != 2'h0) begin
                            alt_d = csbam_pkg::A_GAP; // [RULE22]
                            gcnt_d = agap_q;
                        end
                    end
                end else if (acnt_q != 4'hF) begin
                    acnt_d = acnt_q + 4'h1;
                end
            end
            csbam_pkg::A_GAP: begin
                gcnt_d = gcnt_q - 2'h1;
                if (gcnt_q == 2'h1) begin
                    alt_d = csbam_pkg::A_ACT;
                end
            end
            csbam_pkg::A_END: begin
                alt_d = csbam_pkg::A_IDLE;
            end
            default: begin
                alt_d = csbam_pkg::A_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alt_q <= csbam_pkg::A_IDLE;
            aaddr_q <= 28'h0000000;
            {asz_q, aps_q, agap_q, gcnt_q} <= 8'h00;
            abeats_q <= csbam_pkg::BEAT_ONE;
            aws_q <= 4'h0;
            acnt_q <= 4'h0;
            {awr_q, acs_q, aack_q} <= 3'h0;
        end else begin
            alt_q <= alt_d;
            aaddr_q <= aaddr_d;
            {asz_q, aps_q, agap_q, gcnt_q} <= {asz_d, aps_d, agap_d, gcnt_d};
            abeats_q <= abeats_d;
            aws_q <= aws_d;
            acnt_q <= acnt_d;
            {awr_q, acs_q, aack_q} <= {awr_d, acs_d, aack_d};
        end
    end

    // ****************************************
    // pin registers, built from next state
    // ****************************************
    logic o_st, o_dt, o_on, a_act;
    assign o_st = own_d == csbam_pkg::O_START;
    assign o_dt = own_d == csbam_pkg::O_DATA;
    assign o_on = own_d != csbam_pkg::O_IDLE;
    assign a_act = alt_d == csbam_pkg::A_ACT;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_out <= 28'h0000000;
            {addr_oe, transfer_start_oe, transfer_ack_oe, data_oe} <= 4'h0;
            {transfer_start_n, transfer_ack_n, chip_sel_n, rd_wr_n} <= 4'hF;
            transfer_type <= 2'h0;
            access_type_mode <= 1'b0;
            size_code <= 2'h0;
            byte_we_n <= csbam_pkg::WE_NONE;
            data_out <= 32'h00000000;
            {req_busy, rsp_valid, rsp_error} <= 3'h0;
            rsp_rdata <= 32'h00000000;
        end else begin
            addr_out <= oaddr_d;
            addr_oe <= o_on; // [RULE17]
            transfer_start_n <= !o_st; // [RULE2]
            transfer_start_oe <= o_on;
            transfer_type <= ott_d;
            access_type_mode <= o_st ? ocode_d : osup_d;
            rd_wr_n <= !(o_on && owr_d);
            size_code <= osz_d;
            chip_sel_n <= !((o_st && ocs_d && !oaset_d) || (o_dt && ocs_d) || (a_act && acs_d));
            if (o_dt && owr_d && ocs_d && (!oaset_d || dcnt_d != 8'h00)) begin // [RULE1]
                byte_we_n <= lane_we(ops_d);
            end else if (a_act && awr_d && acs_d && acnt_d != 4'h0) begin
                byte_we_n <= lane_we(aps_d);
            end else begin
                byte_we_n <= csbam_pkg::WE_NONE;
            end
            transfer_ack_n <= !(a_act && aack_d && acnt_d >= aws_d);
            transfer_ack_oe <= aack_d && (alt_d == csbam_pkg::A_ACT || alt_d == csbam_pkg::A_GAP
                                          || alt_d == csbam_pkg::A_END);
            data_out <= odata_d;
            data_oe <= o_on && owr_d;
            req_busy <= o_on;
            rsp_valid <= ok_d || err_d;
            rsp_error <= err_d;
            rsp_rdata <= rdata_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_we_setup_zero: assert property (own_q == csbam_pkg::O_DATA && dcnt_q == 8'h00 && oaset_q // [RULE1]
        |-> byte_we_n == csbam_pkg::WE_NONE) else $error("write enable on zero-wait setup beat");
    a_first_clock: assert property (own_q == csbam_pkg::O_START |-> !transfer_start_n && addr_oe // [RULE2]
        && chip_sel_n == (oaset_q || !ocs_q)) else $error("bad first clock");
    a_second_clock: assert property ($past(own_q) == csbam_pkg::O_START |-> transfer_start_n // [RULE3]
        && access_type_mode == osup_q && chip_sel_n == !ocs_q) else $error("bad second clock");
    a_wait_beat: assert property (own_q == csbam_pkg::O_DATA && !oack && !(bmon_enable && dcnt_q >= bmon_limit) // [RULE5]
        |=> own_q == csbam_pkg::O_DATA && dcnt_q == $past(dcnt_q) + 8'h01) else $error("wait state lost");
    a_bmon_error: assert property (own_q == csbam_pkg::O_DATA && !oack && bmon_enable && dcnt_q >= bmon_limit // [RULE6]
        |=> rsp_valid && rsp_error && own_q == csbam_pkg::O_IDLE) else $error("no bus error");
    a_read_hold: assert property (own_q == csbam_pkg::O_DATA && oack && ohold_q // [RULE8]
        |=> own_q == csbam_pkg::O_HOLD && addr_out == $past(addr_out) && addr_oe) else $error("hold lost");
    a_setup_gap: assert property (own_q == csbam_pkg::O_SETUP |-> chip_sel_n // [RULE9]
        && addr_out != $past(addr_out, 2)) else $error("setup gap wrong");
    a_final_drop: assert property (own_q == csbam_pkg::O_DATA && oack && obeats_q == csbam_pkg::BEAT_ONE // [RULE10]
        |=> chip_sel_n && rsp_valid) else $error("final beat not ended");
    a_alt_latch: assert property (alt_q == csbam_pkg::A_IDLE && bus_granted && !transfer_start_n_in // [RULE12]
        && own_q == csbam_pkg::O_IDLE |=> alt_q == csbam_pkg::A_DEC && asz_q == $past(alt_size)
        && awr_q == $past(alt_write)) else $error("alternate latch wrong");
    a_alt_no_addr: assert property (alt_q != csbam_pkg::A_IDLE |-> !addr_oe) else $error("address driven"); // [RULE17]
    a_alt_release: assert property (alt_q == csbam_pkg::A_END |-> chip_sel_n && transfer_ack_n // [RULE21]
        ##1 !transfer_ack_oe) else $error("ack not released");
    a_alt_gap: assert property (alt_q == csbam_pkg::A_GAP |-> chip_sel_n && transfer_ack_n) // [RULE22]
        else $error("select during gap");
endmodule

// ---- hw/csbam_pkg.sv ----
package csbam_pkg;
    // size and port codes share one encoding
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;
    localparam int AW = 28;
    localparam int DW = 32;
    localparam int BMW = 8;
    localparam int WSW = 4;
    localparam int UPPER_LSB = 24;
    localparam int BASE_LSB = 16;
    localparam logic [3:0] WE_NONE = 4'hF;
    localparam logic [3:0] WE_P32 = 4'h0;
    localparam logic [3:0] WE_P16 = 4'h3;
    localparam logic [3:0] WE_P8 = 4'h7;
    localparam logic [4:0] BEAT_ONE = 5'h01;
    typedef enum logic [4:0] {
        O_IDLE = 5'h01,
        O_START = 5'h02,
        O_DATA = 5'h04,
        O_HOLD = 5'h08,
        O_SETUP = 5'h10
    } csbam_own_e;
    typedef enum logic [4:0] {
        A_IDLE = 5'h01,
        A_DEC = 5'h02,
        A_ACT = 5'h04,
        A_GAP = 5'h08,
        A_END = 5'h10
    } csbam_alt_e;
endpackage

// ---- bench/csbam_mem.sv ----
`timescale 1ns/1ps
// ****************
// memory on the select
// ****************
module csbam_mem (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chip_sel_n,
    input wire logic transfer_start_n,
    input wire logic [27:0] addr_out,
    input wire logic [3:0] waits,
    output logic ack_n,
    output logic [31:0] data
);
    logic [3:0] cnt_q;
    logic [31:0] last_q;
    logic live;
    assign live = !chip_sel_n && transfer_start_n;
    assign ack_n = !(live && cnt_q == waits);
    // deselected lanes flip, so a stale latch cannot pass
    assign data = chip_sel_n ? ~last_q : {4{addr_out[7:0] ^ 8'h5A}};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {cnt_q, last_q} <= '0;
        end else begin
            cnt_q <= (live && ack_n) ? cnt_q + 4'h1 : 4'h0;
            last_q <= data;
        end
    end
endmodule

// ---- bench/csbam_top_test.sv ----
`timescale 1ns/1ps
// ****************
// scenarios
// ****************
module csbam_top_test;
    localparam logic [27:0] AD = 28'h0010040;
    logic clk_sys, rst_n, req_valid, req_write, req_super, req_code, region_read_enable, region_write_enable;
    logic region_burst_enable, address_setup_enable, region_read_hold, region_write_hold, region_auto_ack_enable;
    logic super_code_mask, super_data_mask, user_code_mask, user_data_mask, dflt_burst_enable, dflt_auto_ack_enable;
    logic upper_pins_are_addr, bmon_enable, bus_granted, dram_hit, alt_write, ts_in, mem_ack, ack_wire, req_busy;
    logic rsp_valid, rsp_error, addr_oe, transfer_start_n, transfer_start_oe, access_type_mode, rd_wr_n, data_oe;
    logic chip_sel_n, transfer_ack_n, transfer_ack_oe;
    logic [1:0] req_size, req_type, region_port_size, dflt_port_size, alt_size, transfer_type, size_code;
    logic [3:0] region_wait_count, dflt_wait_count, waits, byte_we_n;
    logic [7:0] bmon_limit;
    logic [8:0] at0;
    logic [11:0] region_base, region_dont_care;
    logic [15:0] cs_t, ack_t, oe_t, aoe_t, rv_t, we_t, ts_t, atm_t;
    logic [27:0] req_addr, addr_in, addr_out;
    logic [27:0] ad_t [16];
    logic [31:0] req_wdata, rsp_rdata, data_out, mem_data;
    int error_cnt, checked;
    assign ack_wire = transfer_ack_oe ? transfer_ack_n : mem_ack;
    csbam_top dut_u (.*, .transfer_start_n_in(ts_in), .transfer_ack_n_in(ack_wire), .data_in(mem_data));
    csbam_mem mem_u (.clk_sys(clk_sys), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .transfer_start_n(transfer_start_n),
        .addr_out(addr_out), .waits(waits), .ack_n(mem_ack), .data(mem_data));
    always #10 clk_sys = ~clk_sys;
    task automatic conclude();
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic trace(input int n);
        for (int i = 0; i < n; i++) begin
            {cs_t[i], ack_t[i], oe_t[i], aoe_t[i], rv_t[i], ts_t[i], atm_t[i]} = {chip_sel_n, transfer_ack_n,
                transfer_ack_oe, addr_oe, rsp_valid, transfer_start_n, access_type_mode};
            we_t[i] = byte_we_n != 4'hF;
            ad_t[i] = addr_out;
            if (i == 0) at0 = {size_code, rd_wr_n, byte_we_n, transfer_type};
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic own(input logic [27:0] a, input logic w, input logic [1:0] s);
        {req_addr, req_write, req_size, req_valid} = {a, w, s, 1'b1};
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
    endtask
    task automatic alt(input logic [27:0] a, input logic w, input logic [1:0] s, input int n);
        {addr_in, alt_write, alt_size, ts_in} = {a, w, s, 1'b0};
        @(posedge clk_sys);
        // released lines flip, so a late latch shows up
        #1 {addr_in, ts_in} = {~a, 1'b1};
        trace(n);
    endtask
    task automatic s_burst();
        {region_port_size, address_setup_enable, region_read_hold} = {csbam_pkg::SZ_BYTE, 2'h3};
        own(AD, 1'b0, csbam_pkg::SZ_WORD);
        trace(7);
        chk(at0, {csbam_pkg::SZ_WORD, 1'b1, csbam_pkg::WE_NONE, 2'h1});
        chk({ts_t[1:0], atm_t[1:0]}, 4'hA);
        chk({cs_t[6:0], rv_t[6:0]}, 14'h36A0);
        chk(ad_t[2], AD);
        chk(ad_t[3], AD + 28'h1);
        chk(ad_t[5], AD + 28'h1);
        chk(rsp_rdata[15:0], 16'h1A1B);
        {region_port_size, address_setup_enable, region_read_hold} = '0;
        for (int w = 0; w < 3; w++) begin
            waits = 4'(w);
            own(AD, 1'b0, csbam_pkg::SZ_LONG);
            trace(6);
            chk(rv_t[5:0], 6'h4 << w);
            chk(rsp_rdata, {4{8'h1A}});
        end
    endtask
    task automatic s_bmon();
        {bmon_enable, waits} = {1'b1, 4'hF};
        own(AD, 1'b0, csbam_pkg::SZ_LONG);
        for (int n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({rsp_valid, rsp_error}, 2'h3);
        if (rsp_valid !== 1'b1) conclude();
        trace(3);
        {region_port_size, address_setup_enable, bmon_enable, waits} = {csbam_pkg::SZ_BYTE, 6'h20};
        own(AD, 1'b1, csbam_pkg::SZ_BYTE);
        chk({data_oe, data_out[31:24], req_busy, transfer_start_oe}, 11'h687);
        trace(6);
        chk(we_t[5:0], 6'h0);
        waits = 4'h1;
        own(AD, 1'b1, csbam_pkg::SZ_BYTE);
        trace(6);
        chk(we_t[5:0] != 6'h0, 1'b1);
    endtask
    task automatic s_alt();
        {address_setup_enable, waits, region_port_size} = {5'h0, csbam_pkg::SZ_WORD};
        {bus_granted, upper_pins_are_addr, super_code_mask, super_data_mask, user_code_mask, user_data_mask} = 6'h2F;
        alt(28'hF010040, 1'b0, csbam_pkg::SZ_LONG, 6);
        chk({cs_t[5:0], ack_t[5:0]}, 12'hE79);
        chk({oe_t[5:0], aoe_t[5:0]}, 12'h380);
        bus_granted = 1'b0;
        alt(AD, 1'b0, csbam_pkg::SZ_LONG, 5);
        chk({cs_t[4:0], oe_t[4:0]}, 10'h3E0);
        {bus_granted, address_setup_enable, region_read_hold} = '1;
        alt(AD, 1'b0, csbam_pkg::SZ_LONG, 8);
        chk({cs_t[7:0], ack_t[7:0]}, 16'hEDED);
        alt(AD, 1'b0, csbam_pkg::SZ_WORD, 8);
        chk(cs_t[7:0], 8'hFD);
        alt(28'h0200000, 1'b0, csbam_pkg::SZ_LONG, 8);
        chk(ack_t[7:0], 8'hF7);
        dram_hit = 1'b1;
        alt(28'h0200000, 1'b0, csbam_pkg::SZ_LONG, 5);
        chk({ack_t[4:0], oe_t[4:0]}, 10'h3E0);
        region_write_enable = 1'b0;
        alt(AD, 1'b1, csbam_pkg::SZ_WORD, 5);
        chk({cs_t[4:0], oe_t[4:0]}, 10'h3E0);
    endtask
    initial begin
        {clk_sys, rst_n, req_valid, req_write, req_code, region_read_hold, region_write_hold, dram_hit} = '0;
        {super_code_mask, super_data_mask, user_code_mask, user_data_mask, dflt_burst_enable, bmon_enable} = '0;
        {bus_granted, alt_write, req_size, alt_size, region_wait_count, region_dont_care, waits, req_addr} = '0;
        {ts_in, req_super, region_read_enable, region_write_enable, region_burst_enable, region_auto_ack_enable} = '1;
        {dflt_auto_ack_enable, upper_pins_are_addr, address_setup_enable} = 3'h6;
        {addr_in, dflt_port_size, region_port_size, req_type, dflt_wait_count} = {32'h0, 6'h12};
        {req_wdata, region_base, bmon_limit} = {32'hA1B2C3D4, 12'h001, 8'h04};
        {error_cnt, checked} = '0;
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        chk({chip_sel_n, transfer_ack_oe, addr_oe, byte_we_n}, 7'h4F);
        s_burst();
        s_bmon();
        s_alt();
        conclude();
    end
endmodule
